// file: include/bil_pkg.sv
// Package: constants, types and helpers of the boot image loader
// How it works
// - Hold device in reset while reset pin low
// - Pin pull-downs enabled while reset pin low
// - Internal reset delay before boot starts
// - Security bit 5 picks OTP, else flash
// - OTP fetch starts at address zero
// - Image is size word, program, check word
// - Size and check words least byte first
// - Magic check word skips CRC verification
// - Program loads and runs from address zero
// - CRC covers size word and program only
// - CRC uses reflected polynomial EDB88320
// - CRC preset all ones, residue inverted
// - Strap pins select PLL ratio settings
// - Core clock follows PLL setting formula
// - PLL settings rewritable through register
package bil_pkg;
   // Timing of the internal reset sequence
   localparam int CLK_NS = 100;
   localparam int RST_MIN_NS = 15000;
   localparam int RST_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
   // Boot source and image constants
   localparam int SEC_BOOT_BIT = 5;
   localparam int MEM_AW = 16;
   localparam logic [15:0] MEM_START = 16'h0000;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
   // Register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IRQ_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_PLL_CFG = 8'h0C;
   localparam logic [7:0] REG_CRC = 8'h10;
   localparam logic [7:0] REG_SIZE = 8'h14;
   // PLL configuration field positions and reset values
   localparam int PLL_R_LSB = 0;
   localparam int PLL_F_LSB = 6;
   localparam int PLL_PDIV_LSB = 18;
   localparam logic [5:0] PLL_R_RST = 6'h00;
   localparam logic [2:0] PLL_PDIV_RST = 3'h1;
   localparam int VCO_MIN_KHZ = 260000;
   localparam int VCO_MAX_KHZ = 1300000;
   // Strap ratios
   localparam int RATIO_00 = 40;
   localparam int RATIO_11 = 16;
   localparam int RATIO_10 = 8;
   localparam int RATIO_01 = 4;
   // Interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_VCO = 2;
   localparam int IRQ_W = 3;

   typedef enum logic [2:0] {
      ST_HOLD, ST_IRST, ST_FETCH, ST_WAIT, ST_DONE, ST_ERR
   } bil_state_type;
   typedef enum logic [1:0] {PH_SIZE, PH_PROG, PH_CHECK} bil_phase_type;

   // Loop setting is ratio times four minus one
   function automatic logic [11:0] bil_loop_of(input logic [1:0] strap);
      int r;
      unique case (strap)
         2'h0: r = RATIO_00;
         2'h3: r = RATIO_11;
         2'h2: r = RATIO_10;
         default: r = RATIO_01;
      endcase
      return 12'(r * 4 - 1);
   endfunction

   // One byte through the reflected CRC, least bit first
   function automatic logic [31:0] bil_crc_byte(input logic [31:0] c,
                                                input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

// file: logic/bil_loader.sv
// Boot sequencer: reset hold, image load with CRC, PLL setup
module bil_loader #(
   parameter int ADDR_W = 18,
   parameter int OSC_KHZ = 10000
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic rst_n_i,
   input wire logic [1:0] strap_i,
   input wire logic [31:0] sec_reg_i,
   output logic mem_rd_o,
   output logic mem_sel_otp_o,
   output logic [15:0] mem_addr_o,
   input wire logic [7:0] mem_data_i,
   input wire logic mem_vld_i,
   output logic ram_we_o,
   output logic [ADDR_W-1:0] ram_addr_o,
   output logic [7:0] ram_wdata_o,
   output logic core_run_o,
   output logic [ADDR_W-1:0] core_pc_o,
   output logic boot_err_o,
   output logic gpio_pd_o,
   output logic [5:0] pll_in_div_o,
   output logic [11:0] pll_loop_o,
   output logic [2:0] pll_post_div_o,
   output logic [31:0] core_khz_o,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o
);
   localparam int DLY_W = $clog2(bil_pkg::RST_CYC + 1);

   // Whole state of the block
   typedef struct packed {
      logic rst_m1;                  // Reset pin, first sync stage
      logic rst_s;                   // Reset pin, synchronised
      logic [1:0] strap_m1;          // Straps, first sync stage
      logic [1:0] strap_s;           // Straps, synchronised
      bil_pkg::bil_state_type st;    // Sequencer state
      bil_pkg::bil_phase_type phase; // Image section being read
      logic [DLY_W-1:0] dly;         // Internal reset counter
      logic [1:0] bcnt;              // Byte within current word
      logic [31:0] word;             // Word being assembled
      logic [31:0] size;             // Captured program size
      logic [31:0] words_left;       // Program words still due
      logic [31:0] crc;              // Running CRC
      logic src_otp;                 // Boot source latch
      logic mem_rd;
      logic [15:0] mem_addr;
      logic ram_we;
      logic [ADDR_W-1:0] ram_next;   // Next RAM byte address
      logic [ADDR_W-1:0] ram_wa;
      logic [7:0] ram_wd;
      logic run;
      logic [ADDR_W-1:0] pc;
      logic boot_err;
      logic gpio_pd;
      logic [5:0] pll_r;
      logic [11:0] pll_f;
      logic [2:0] pll_pdiv;
      logic [31:0] core_khz;
      logic vco_ok;                  // Last settings inside VCO band
      logic [bil_pkg::IRQ_W-1:0] irq_st;
      logic [bil_pkg::IRQ_W-1:0] irq_msk;
      logic irq;
      logic [31:0] rdata;
   } bil_regs_type;

   bil_regs_type s_q;
   bil_regs_type s_d;
   logic [31:0] byte_word;           // Word with the new byte on top
   logic [bil_pkg::IRQ_W-1:0] ev;    // Events of this cycle
   logic [31:0] num;                 // Oscillator times (F+1)
   logic [31:0] vco;                 // Pre-divider frequency in kHz

   // Next-state logic of sequencer, registers and PLL
   always_comb begin
      s_d = s_q;
      ev = '0;
      s_d.rst_m1 = rst_n_i;
      s_d.rst_s = s_q.rst_m1;
      s_d.strap_m1 = strap_i;
      s_d.strap_s = s_q.strap_m1;
      s_d.mem_rd = 1'b0;
      s_d.ram_we = 1'b0;
      s_d.rdata = '0;
      // Bytes enter at the top, so the first one ends lowest
      // least byte first
      byte_word = {mem_data_i, s_q.word[31:8]};
      unique case (s_q.st)
         bil_pkg::ST_HOLD: begin
            s_d.gpio_pd = 1'b1;
            s_d.pll_f = bil_pkg::bil_loop_of(s_q.strap_s);
            s_d.pll_r = bil_pkg::PLL_R_RST;
            s_d.pll_pdiv = bil_pkg::PLL_PDIV_RST;
            if (s_q.rst_s) begin
               s_d.st = bil_pkg::ST_IRST;
               s_d.dly = '0;
               s_d.gpio_pd = 1'b0;
            end
         end
         bil_pkg::ST_IRST: begin
            s_d.dly = s_q.dly + 1'b1;
            if (s_q.dly == DLY_W'(bil_pkg::RST_CYC - 1)) begin
               s_d.st = bil_pkg::ST_FETCH;
               s_d.src_otp = sec_reg_i[bil_pkg::SEC_BOOT_BIT];
               s_d.mem_addr = bil_pkg::MEM_START;
               s_d.phase = bil_pkg::PH_SIZE;
               s_d.bcnt = 2'h0;
               s_d.crc = bil_pkg::CRC_INIT;
               s_d.ram_next = '0;
               s_d.boot_err = 1'b0;
               s_d.word = '0;
            end
         end
         bil_pkg::ST_FETCH: begin
            // One byte requested at a time
            s_d.mem_rd = 1'b1;
            s_d.st = bil_pkg::ST_WAIT;
         end
         bil_pkg::ST_WAIT: begin
            if (mem_vld_i) begin
               s_d.word = byte_word;
               s_d.bcnt = s_q.bcnt + 1'b1;
               s_d.mem_addr = s_q.mem_addr + 1'b1;
               s_d.st = bil_pkg::ST_FETCH;
               if (s_q.phase != bil_pkg::PH_CHECK) begin
                  s_d.crc = bil_pkg::bil_crc_byte(s_q.crc, mem_data_i);
               end
               unique case (s_q.phase)
                  bil_pkg::PH_SIZE: begin
                     if (s_q.bcnt == 2'h3) begin
                        s_d.size = byte_word;
                        s_d.words_left = byte_word;
                        // An empty program goes straight to the check
                        s_d.phase = (byte_word == '0) ?
                           bil_pkg::PH_CHECK : bil_pkg::PH_PROG;
                     end
                  end
                  bil_pkg::PH_PROG: begin
                     s_d.ram_we = 1'b1;
                     s_d.ram_wa = s_q.ram_next;
                     s_d.ram_wd = mem_data_i;
                     s_d.ram_next = s_q.ram_next + 1'b1;
                     if (s_q.bcnt == 2'h3) begin
                        s_d.words_left = s_q.words_left - 1'b1;
                        if (s_q.words_left == 32'h00000001) begin
                           s_d.phase = bil_pkg::PH_CHECK;
                        end
                     end
                  end
                  bil_pkg::PH_CHECK: begin
                     if (s_q.bcnt == 2'h3) begin
                        if (byte_word == bil_pkg::CRC_SKIP ||
                            byte_word == ~s_q.crc) begin
                           s_d.st = bil_pkg::ST_DONE;
                           s_d.run = 1'b1;
                           s_d.pc = '0;
                           ev[bil_pkg::IRQ_DONE] = 1'b1;
                        end else begin
                           s_d.st = bil_pkg::ST_ERR;
                           s_d.boot_err = 1'b1;
                           ev[bil_pkg::IRQ_ERR] = 1'b1;
                        end
                     end
                  end
                  default: begin
                     s_d.phase = bil_pkg::PH_SIZE;
                  end
               endcase
            end
         end
         bil_pkg::ST_DONE: begin
            s_d.run = 1'b1;
         end
         bil_pkg::ST_ERR: begin
            s_d.run = 1'b0;
         end
         default: begin
            s_d.st = bil_pkg::ST_HOLD;
         end
      endcase
      if (!s_q.rst_s) begin
         s_d.st = bil_pkg::ST_HOLD;
         s_d.gpio_pd = 1'b1;
         s_d.run = 1'b0;
         s_d.mem_rd = 1'b0;
         s_d.ram_we = 1'b0;
      end
      // Register writes; PLL write also flags an unsafe VCO band
      if (reg_we_i) begin
         unique case (reg_addr_i)
            bil_pkg::REG_IRQ_MASK: begin
               s_d.irq_msk = reg_wdata_i[bil_pkg::IRQ_W-1:0];
            end
            bil_pkg::REG_PLL_CFG: begin
               s_d.pll_r = reg_wdata_i[bil_pkg::PLL_R_LSB +: 6];
               s_d.pll_f = reg_wdata_i[bil_pkg::PLL_F_LSB +: 12];
               s_d.pll_pdiv = reg_wdata_i[bil_pkg::PLL_PDIV_LSB +: 3];
            end
            default: begin
               s_d.irq_msk = s_q.irq_msk;
            end
         endcase
      end
      num = 32'(OSC_KHZ) * ({20'h00000, s_q.pll_f} + 32'h1);
      vco = num / (32'h2 * ({26'h0000000, s_q.pll_r} + 32'h1));
      s_d.core_khz = vco / ({29'h00000000, s_q.pll_pdiv} + 32'h1);
      // Band check only warns; the limits are software's to keep
      s_d.vco_ok = (vco >= 32'(bil_pkg::VCO_MIN_KHZ)) &&
                   (vco <= 32'(bil_pkg::VCO_MAX_KHZ));
      if (s_q.vco_ok != s_d.vco_ok && !s_d.vco_ok) begin
         ev[bil_pkg::IRQ_VCO] = 1'b1;
      end
      // Sticky status: a new event beats a same-cycle clear
      s_d.irq_st = s_q.irq_st | ev;
      if (reg_we_i && reg_addr_i == bil_pkg::REG_IRQ_STAT) begin
         s_d.irq_st = (s_q.irq_st & ~reg_wdata_i[bil_pkg::IRQ_W-1:0]) |
                      ev;
      end
      s_d.irq = |(s_d.irq_st & s_d.irq_msk);
      // Read data valid only in the cycle after the strobe
      if (reg_re_i) begin
         unique case (reg_addr_i)
            bil_pkg::REG_STATUS: begin
               s_d.rdata = {24'h000000, s_q.vco_ok, s_q.src_otp,
                            s_q.boot_err, s_q.run, 1'b0, s_q.st};
            end
            bil_pkg::REG_IRQ_STAT: begin
               s_d.rdata = 32'(s_q.irq_st);
            end
            bil_pkg::REG_IRQ_MASK: begin
               s_d.rdata = 32'(s_q.irq_msk);
            end
            bil_pkg::REG_PLL_CFG: begin
               s_d.rdata = {11'h000, s_q.pll_pdiv, s_q.pll_f, s_q.pll_r};
            end
            bil_pkg::REG_CRC: begin
               s_d.rdata = ~s_q.crc;
            end
            bil_pkg::REG_SIZE: begin
               s_d.rdata = s_q.size;
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end
   end

   // State register; reset loads constants only
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.st <= bil_pkg::ST_HOLD;
         s_q.gpio_pd <= 1'b1;
         s_q.crc <= bil_pkg::CRC_INIT;
         s_q.pll_pdiv <= bil_pkg::PLL_PDIV_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign mem_rd_o = s_q.mem_rd;
   assign mem_sel_otp_o = s_q.src_otp;
   assign mem_addr_o = s_q.mem_addr;
   assign ram_we_o = s_q.ram_we;
   assign ram_addr_o = s_q.ram_wa;
   assign ram_wdata_o = s_q.ram_wd;
   assign core_run_o = s_q.run;
   assign core_pc_o = s_q.pc;
   assign boot_err_o = s_q.boot_err;
   assign gpio_pd_o = s_q.gpio_pd;
   assign pll_in_div_o = s_q.pll_r;
   assign pll_loop_o = s_q.pll_f;
   assign pll_post_div_o = s_q.pll_pdiv;
   assign core_khz_o = s_q.core_khz;
   assign reg_rdata_o = s_q.rdata;
   assign irq_o = s_q.irq;

   // Checks on the sequencer
   localparam int A_RST_CYC = bil_pkg::RST_CYC;
   logic [ADDR_W-1:0] a_wcnt_q;      // RAM writes since boot start
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         a_wcnt_q <= '0;
      end else if (s_q.st == bil_pkg::ST_IRST) begin
         a_wcnt_q <= '0;
      end else if (ram_we_o) begin
         a_wcnt_q <= a_wcnt_q + 1'b1;
      end
   end

   default clocking a_cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_chk_last;
      s_q.st == bil_pkg::ST_WAIT && mem_vld_i &&
      s_q.phase == bil_pkg::PH_CHECK && s_q.bcnt == 2'h3;
   endsequence
   sequence s_boot_go;
      s_q.st == bil_pkg::ST_IRST ##1 s_q.st == bil_pkg::ST_FETCH;
   endsequence

   a_reset_hold: assert property (
      !s_q.rst_s |=> s_q.st == bil_pkg::ST_HOLD && gpio_pd_o && !core_run_o)
      else $error("reset pin low did not hold the device");
   a_irst_delay: assert property (
      $rose(s_q.st == bil_pkg::ST_IRST) && s_q.rst_s
      |-> ##A_RST_CYC s_q.st != bil_pkg::ST_IRST)
      else $error("internal reset length wrong");
   a_boot_source: assert property (
      s_boot_go |=> mem_rd_o && mem_addr_o == 16'h0000 &&
      mem_sel_otp_o == $past(sec_reg_i[bil_pkg::SEC_BOOT_BIT], 2))
      else $error("boot source or start address wrong");
   a_ram_order: assert property (
      ram_we_o |-> ram_addr_o == a_wcnt_q)
      else $error("program byte written out of order");
   a_run_zero: assert property (
      $rose(core_run_o) |-> core_pc_o == '0 && !boot_err_o)
      else $error("program not started at address zero");
   a_crc_skip: assert property (
      s_chk_last and (byte_word == bil_pkg::CRC_SKIP) |=> core_run_o)
      else $error("magic check word did not skip the CRC");
   a_crc_bad: assert property (
      s_chk_last and (byte_word != bil_pkg::CRC_SKIP &&
      byte_word != ~s_q.crc) |=> boot_err_o && !core_run_o ##1 !core_run_o)
      else $error("bad CRC did not block the start");
   a_crc_frozen: assert property (
      s_q.phase == bil_pkg::PH_CHECK && $past(s_q.phase) ==
      bil_pkg::PH_CHECK |-> $stable(s_q.crc))
      else $error("CRC moved during the check word");
   a_strap_pll: assert property (
      s_q.st == bil_pkg::ST_HOLD && !reg_we_i |=> pll_in_div_o == 6'h00 &&
      pll_loop_o == bil_pkg::bil_loop_of($past(s_q.strap_s)))
      else $error("strap ratio not applied");
   a_pll_write: assert property (
      reg_we_i && reg_addr_i == bil_pkg::REG_PLL_CFG |=>
      pll_in_div_o == $past(reg_wdata_i[bil_pkg::PLL_R_LSB +: 6]) &&
      pll_loop_o == $past(reg_wdata_i[bil_pkg::PLL_F_LSB +: 12]) &&
      pll_post_div_o == $past(reg_wdata_i[bil_pkg::PLL_PDIV_LSB +: 3]))
      else $error("PLL register write not applied");
endmodule

// file: tb/bil_mem_model.sv
// Boot memory model: OTP and flash byte stores answering fetches
module bil_mem_model (
   input wire logic clk_i,
   input wire logic mem_rd_i,
   input wire logic mem_sel_otp_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic slow_i,
   output logic [7:0] mem_data_o,
   output logic mem_vld_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] img [2][256]; // Index 1 is OTP, index 0 is flash
   logic pend = 1'b0; // A fetch is waiting for its byte
   logic src; // Store named by the fetch
   logic [7:0] adr; // Byte address of the fetch
   int gap; // Extra wait cycles of a slow answer

   // Idle state before the first fetch
   initial begin
      mem_data_o = 8'h5A;
      mem_vld_o = 1'b0;
   end

   // One answer per fetch; idle data toggles so stale bytes never match
   always @(posedge clk_i) begin
      mem_vld_o <= 1'b0;
      mem_data_o <= ~mem_data_o;
      if (mem_rd_i === 1'b1) begin
         pend = 1'b1;
         src = mem_sel_otp_i;
         adr = mem_addr_i[7:0];
         gap = slow_i ? $urandom_range(4, 0) : 0;
      end else if (pend && gap > 0) begin
         gap--;
      end else if (pend) begin
         mem_vld_o <= 1'b1;
         mem_data_o <= img[src][adr];
         pend = 1'b0;
      end
   end
endmodule

// file: tb/boot_image_loader_pll_setup_bench.sv
// Self-checking bench of the boot sequencer with its boot memory
module boot_image_loader_pll_setup_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, rst_n_i = 1'b0, slow = 1'b0;
   logic [1:0] strap_i = 2'h0;
   logic [31:0] sec_reg_i = 32'h0, reg_wdata_i = 32'h0;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_we_i = 1'b0, reg_re_i = 1'b0, rd_pend = 1'b0;
   logic mem_rd_o, mem_sel_otp_o, mem_vld_i, ram_we_o, core_run_o;
   logic boot_err_o, gpio_pd_o, irq_o;
   logic [15:0] mem_addr_o;
   logic [7:0] mem_data_i, ram_wdata_o;
   logic [17:0] ram_addr_o, core_pc_o;
   logic [5:0] pll_in_div_o;
   logic [11:0] pll_loop_o;
   logic [2:0] pll_post_div_o;
   logic [31:0] core_khz_o, reg_rdata_o;
   logic [31:0] ram_q [$]; // Expected RAM writes, address and byte
   logic [31:0] rd_q [$]; // Expected register read data
   int n_fail = 0, n_compared = 0;
   int ftab [4] = '{159, 15, 31, 63}; // Loop setting by strap value

   bil_loader bil_loader_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .rst_n_i(rst_n_i), .strap_i(strap_i), .sec_reg_i(sec_reg_i),
      .mem_rd_o(mem_rd_o), .mem_sel_otp_o(mem_sel_otp_o),
      .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
      .mem_vld_i(mem_vld_i), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
      .ram_wdata_o(ram_wdata_o), .core_run_o(core_run_o),
      .core_pc_o(core_pc_o), .boot_err_o(boot_err_o),
      .gpio_pd_o(gpio_pd_o), .pll_in_div_o(pll_in_div_o),
      .pll_loop_o(pll_loop_o), .pll_post_div_o(pll_post_div_o),
      .core_khz_o(core_khz_o), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
      .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

   bil_mem_model bil_mem_model_i (.clk_i(clk_i), .mem_rd_i(mem_rd_o),
      .mem_sel_otp_i(mem_sel_otp_o), .mem_addr_i(mem_addr_o),
      .slow_i(slow), .mem_data_o(mem_data_i), .mem_vld_o(mem_vld_i));

   // Free-running 10 MHz clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // Compare one value and keep the tallies
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask

   // Report the tallies and end the run
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Register write: one strobe cycle, then released
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
   endtask

   // Register read: the monitor checks the word a cycle later
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
   endtask

   // Reference CRC step, written apart from the design's own
   function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                           input logic [7:0] b);
      c = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++)
         c = c[0] ? (c >> 1) ^ bil_pkg::CRC_POLY : c >> 1;
      return c;
   endfunction

   // The wanted store gets the byte, the other its inverse
   task automatic put(input logic s, input int a, input logic [7:0] b);
      bil_mem_model_i.img[s][a] = b;
      bil_mem_model_i.img[!s][a] = ~b;
   endtask

   // Load an image, release the reset pin, follow the boot to its end
   task automatic boot(input logic otp, input int words, input int mode);
      logic [31:0] crc, chk, sz;
      logic [7:0] b;
      int n;
      crc = bil_pkg::CRC_INIT;
      sz = 32'(words);
      rst_n_i <= 1'b0;
      sec_reg_i <= {26'h0000000, otp, 5'h00};
      cyc(4);
      cmp(32'(core_run_o), 32'h0);
      cmp(32'(gpio_pd_o), 32'h1);
      for (int i = 0; i < 4 + 4 * words; i++) begin
         b = i < 4 ? sz[8 * i +: 8] : 8'($urandom);
         put(otp, i, b);
         crc = crc_upd(crc, b);
         if (i >= 4)
            ram_q.push_back({6'h00, 18'(i - 4), b});
      end
      chk = mode == 1 ? bil_pkg::CRC_SKIP : ~crc ^ 32'(mode == 2);
      for (int i = 0; i < 4; i++)
         put(otp, 4 + 4 * words + i, chk[8 * i +: 8]);
      rst_n_i <= 1'b1;
      for (n = 0; n < 2000 && mem_rd_o !== 1'b1; n++)
         @(posedge clk_i);
      cmp(32'(n >= 150 && n <= 1500), 32'h1);
      if (n == 2000)
         summarize();
      cmp({15'h0000, mem_sel_otp_o, mem_addr_o}, {15'h0, otp, 16'h0});
      for (n = 0; n < 3000 && !(core_run_o || boot_err_o); n++)
         @(posedge clk_i);
      if (n == 3000) begin
         n_fail++;
         summarize();
      end
      cmp(32'({core_run_o, boot_err_o}), mode == 2 ? 1 : 2);
      cmp(32'(core_pc_o), 32'h0);
      cyc(2);
      cmp(ram_q.size(), 32'h0);
      reg_rd(bil_pkg::REG_SIZE, sz);
      reg_rd(bil_pkg::REG_CRC, ~crc);
   endtask

   // Pair each RAM write and read answer with the oldest note
   always @(posedge clk_i) begin
      if (ram_we_o === 1'b1)
         cmp({6'h00, ram_addr_o, ram_wdata_o},
             ram_q.size() != 0 ? ram_q.pop_front() : 'x);
      if (rd_pend)
         cmp(reg_rdata_o, rd_q.size() != 0 ? rd_q.pop_front() : 'x);
      rd_pend <= reg_re_i;
   end

   // Main sequence
   initial begin
      void'($urandom(56));
      cyc(10);
      // Straps change only under system reset, then stay put
      for (int p = 3; p >= 0; p--) begin
         // Reset would wipe a read answer still standing
         cyc(2);
         sys_rst_i <= 1'b1;
         strap_i <= 2'(p);
         cyc(3);
         cmp(32'(gpio_pd_o), 32'h1);
         sys_rst_i <= 1'b0;
         cyc(5);
         cmp(32'(pll_loop_o), ftab[p]);
         cmp(32'({pll_in_div_o, pll_post_div_o}), 32'h1);
         cmp(core_khz_o, 2500 * (ftab[p] + 1));
         reg_rd(bil_pkg::REG_PLL_CFG, 32'h40000 | ftab[p] << 6);
      end
      reg_rd(8'h20, 32'h0); // unmapped read
      reg_wr(bil_pkg::REG_IRQ_STAT, 32'h7);
      reg_wr(bil_pkg::REG_IRQ_MASK, 32'h1);
      boot(1'b0, $urandom_range(16, 1), 0);
      cyc(2);
      cmp(32'(irq_o), 32'h1); // unmasked done raises the line
      reg_rd(bil_pkg::REG_STATUS, 32'h94);
      reg_rd(bil_pkg::REG_IRQ_STAT, 32'h1);
      reg_wr(bil_pkg::REG_IRQ_MASK, 32'h2);
      cyc(3);
      cmp(32'(irq_o), 32'h0); // masked status keeps the line low
      reg_wr(bil_pkg::REG_IRQ_STAT, 32'h1);
      reg_rd(bil_pkg::REG_IRQ_STAT, 32'h0);
      // Run-time PLL change with the input divider in play, post divider at 0
      reg_wr(bil_pkg::REG_PLL_CFG, 32'h31C1);
      reg_wr(8'h24, 32'hFFFFFFFF); // unmapped write ignored
      cyc(3);
      cmp(32'({pll_in_div_o, pll_loop_o, pll_post_div_o}),
          {11'h000, 6'h01, 12'h0C7, 3'h0});
      cmp(core_khz_o, 32'd500000);
      reg_rd(bil_pkg::REG_PLL_CFG, 32'h31C1);
      slow <= 1'b1;
      boot(1'b1, 0, 1);
      reg_wr(bil_pkg::REG_IRQ_STAT, 32'h7);
      boot(1'b0, $urandom_range(16, 1), 2);
      cyc(2);
      cmp(32'(irq_o), 32'h1);
      reg_rd(bil_pkg::REG_STATUS, 32'hA5);
      reg_rd(bil_pkg::REG_IRQ_STAT, 32'h2);
      cyc(3);
      summarize();
   end
endmodule
